// ---- logic/cfs_pkg.sv ----
/*
  Shared definitions for the converter fault supervisor: register offsets,
  reset values, enable-source codes, fault flag layout, timing figures,
  state encoding and the packed carriers used by the supervisor.
  Assumes a single 125 MHz clock; analog comparators deliver levels.
*/
// How it works
// - Under pin control the output runs only while the enable pin is high.
// - Config 16h follows the pin only; config 1Ah follows the run bit only.
// - Config 1Eh needs bit and pin; 12h always off; 0xh always on.
// - Power-good held low until soft start, released a delay after threshold.
// - Any master fault latches power-good low until a new soft start; a slave releases it once its fault clears.
// - Shared power-good line carries phase faults; slave detection only in run state, after a short grace count.
// - Power-good is clamped low whenever input supply is missing.
// - Alert output is driven whenever any warning flag is stored.
// - Clear-faults command resets every stored warning and fault flag.
// - Under-voltage below 70 percent turns off after 1 ms, hiccups 16 ms.
// - Under-voltage detection arms only 1.5 ms after soft start completes.
// - Over-voltage above 120 percent enters sink mode to pull output down.
// - If sinking reaches the under-voltage level, restart after hiccup delay.
// - No start attempt while over-voltage persists.
// - Over-temperature shuts down; restart automatically once it cools.
// - Excess output current enters the short-circuit condition.
// - Short circuit hiccups repeatedly and resumes by itself once cleared.
// - A slave reports its OV, UV and OT faults by pulling power-good low.
// - The master phase owns start-up, shut-off and protection, except a slave's own OV sink and lockout stop.
// - Start above start threshold, stop below shutdown limit, with hysteresis.
`default_nettype none
package cfs_pkg;
  // Clock and timing figures
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned UV_DEBOUNCE_US = 1000;
  localparam int unsigned HICCUP_US      = 16000;
  localparam int unsigned UV_ARM_US      = 1500;
  localparam int unsigned PG_DELAY_US    = 1000;
  localparam int unsigned UV_DEBOUNCE_CYC = UV_DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned HICCUP_CYC      = HICCUP_US * CLK_MHZ;
  localparam int unsigned UV_ARM_CYC      = UV_ARM_US * CLK_MHZ;
  localparam int unsigned PG_DELAY_CYC    = PG_DELAY_US * CLK_MHZ;
  localparam int unsigned SLAVE_GRACE_CYC = 4;
  localparam int unsigned TW              = 22;

  // Register offsets and reset values
  localparam logic [7:0] ADDR_RUN_CMD = 8'h01;
  localparam logic [7:0] ADDR_ENA_CFG = 8'h02;
  localparam logic [7:0] RUN_CMD_RST  = 8'h00;
  localparam logic [7:0] ENA_CFG_RST  = 8'h16;
  localparam int unsigned RUN_ON_BIT  = 7;

  // Enable-source codes
  localparam logic [7:0] CFG_PIN_ONLY   = 8'h16;
  localparam logic [7:0] CFG_CMD_ONLY   = 8'h1a;
  localparam logic [7:0] CFG_BOTH       = 8'h1e;
  localparam logic [7:0] CFG_ALWAYS_OFF = 8'h12;
  localparam logic [3:0] CFG_ON_HIGH    = 4'h0;

  // Stored flag positions
  localparam int unsigned FLAG_W      = 6;
  localparam int unsigned FLG_LOCKOUT = 0;
  localparam int unsigned FLG_UV      = 1;
  localparam int unsigned FLG_OV      = 2;
  localparam int unsigned FLG_OT      = 3;
  localparam int unsigned FLG_OC      = 4;
  localparam int unsigned FLG_SLAVE   = 5;

  typedef enum logic [2:0] {
    ST_OFF, ST_SOFT, ST_PGWAIT, ST_RUN, ST_SINK, ST_HICCUP, ST_OTWAIT
  } cfs_state_t;

  // Pin levels, all from outside the clock domain
  typedef struct packed {
    logic is_master;
    logic pg_in;
    logic run_in;
    logic enable_pin;
    logic fb_ready;
    logic soft_start_done;
    logic over_current;
    logic over_temperature;
    logic output_over_voltage;
    logic output_under_voltage;
    logic input_lockout;
  } cfs_pins_t;

  // Whole supervisor state
  typedef struct packed {
    cfs_state_t        state;
    logic [TW-1:0]     timer;
    logic [TW-1:0]     arm_cnt;
    logic [TW-1:0]     uv_cnt;
    logic              uv_armed;
    logic              run;
    logic              sink;
    logic              pg_oe;
    logic              alert_oe;
    logic [FLAG_W-1:0] flags;
    logic [7:0]        run_cmd;
    logic [7:0]        ena_cfg;
    logic [7:0]        rdata;
    logic              rvalid;
  } cfs_core_t;
endpackage
`default_nettype wire

// ---- logic/cfs_supervisor.sv ----
/*
  Converter fault supervisor: enable-source selection, soft-start and
  power-good sequencing, UV/OV/OT/short-circuit protection with hiccup,
  stored flags with alert, and the slave-phase fault reporting path.
  Assumes the serial engine outside presents decoded register accesses
  and a clear-faults strobe on this clock; analog levels arrive async.
*/
`timescale 1ns/1ps
`default_nettype none
module cfs_supervisor #(
  parameter int unsigned UV_DEBOUNCE_CYC = cfs_pkg::UV_DEBOUNCE_CYC,
  parameter int unsigned HICCUP_CYC      = cfs_pkg::HICCUP_CYC,
  parameter int unsigned UV_ARM_CYC      = cfs_pkg::UV_ARM_CYC,
  parameter int unsigned PG_DELAY_CYC    = cfs_pkg::PG_DELAY_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Register access from the serial engine
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       clear_faults,
  output var  logic [7:0] reg_rdata,
  output var  logic       reg_rvalid,
  // Analog comparator and strap levels
  input  wire logic       input_lockout,
  input  wire logic       output_under_voltage,
  input  wire logic       output_over_voltage,
  input  wire logic       over_temperature,
  input  wire logic       over_current,
  input  wire logic       soft_start_done,
  input  wire logic       fb_ready,
  input  wire logic       is_master,
  // Host and phase pins
  input  wire logic       enable_pin,
  input  wire logic       run_in,
  input  wire logic       power_good_output_i,
  output var  logic       power_good_output_o,
  output var  logic       power_good_output_oe,
  output var  logic       alert_output_n_o,
  output var  logic       alert_output_n_oe,
  // Power stage control and flags
  output var  logic       converter_run,
  output var  logic       sink_mode,
  output var  logic [5:0] fault_flags
);
  localparam int unsigned TW = cfs_pkg::TW;

  cfs_pkg::cfs_pins_t pins_raw;
  cfs_pkg::cfs_pins_t s;
  cfs_pkg::cfs_core_t core_reg;
  cfs_pkg::cfs_core_t core_next;
  logic [cfs_pkg::FLAG_W-1:0] flag_set;
  logic                       want_on;
  logic                       active;

  // Output on/off decision from the enable-source code
  function automatic logic cfs_want(input logic [7:0] cfg, input logic bit_on,
                                    input logic pin);
    if (cfg == cfs_pkg::CFG_PIN_ONLY) begin
      cfs_want = pin;
    end else if (cfg == cfs_pkg::CFG_CMD_ONLY) begin
      cfs_want = bit_on;
    end else if (cfg == cfs_pkg::CFG_BOTH) begin
      cfs_want = bit_on & pin;
    end else if (cfg[7:4] == cfs_pkg::CFG_ON_HIGH) begin
      cfs_want = 1'b1;
    end else begin
      cfs_want = 1'b0;
    end
  endfunction

  // Pin levels in one carrier
  always_comb begin
    pins_raw.is_master            = is_master;
    pins_raw.pg_in                = power_good_output_i;
    pins_raw.run_in               = run_in;
    pins_raw.enable_pin           = enable_pin;
    pins_raw.fb_ready             = fb_ready;
    pins_raw.soft_start_done      = soft_start_done;
    pins_raw.over_current         = over_current;
    pins_raw.over_temperature     = over_temperature;
    pins_raw.output_over_voltage  = output_over_voltage;
    pins_raw.output_under_voltage = output_under_voltage;
    pins_raw.input_lockout        = input_lockout;
  end

  // Every async level passes two flops before any decision
  cfs_sync #(
    .W ($bits(cfs_pkg::cfs_pins_t))
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (pins_raw),
    .q   (s)
  );

  assign want_on = cfs_want(core_reg.ena_cfg, core_reg.run_cmd[cfs_pkg::RUN_ON_BIT],
                            s.enable_pin);
  assign active  = (core_reg.state == cfs_pkg::ST_SOFT) ||
                   (core_reg.state == cfs_pkg::ST_PGWAIT) ||
                   (core_reg.state == cfs_pkg::ST_RUN);

  // Next state: registers, flags, sequencing and protection
  always_comb begin
    core_next        = core_reg;
    core_next.rvalid = 1'b0;
    flag_set         = '0;

    // Register writes and reads; unmapped reads answer zero
    if (reg_wr && reg_addr == cfs_pkg::ADDR_RUN_CMD) begin
      core_next.run_cmd = reg_wdata;
    end
    if (reg_wr && reg_addr == cfs_pkg::ADDR_ENA_CFG) begin
      core_next.ena_cfg = reg_wdata;
    end
    if (reg_rd) begin
      core_next.rvalid = 1'b1;
      if (reg_addr == cfs_pkg::ADDR_RUN_CMD) begin
        core_next.rdata = core_reg.run_cmd;
      end else if (reg_addr == cfs_pkg::ADDR_ENA_CFG) begin
        core_next.rdata = core_reg.ena_cfg;
      end else begin
        core_next.rdata = 8'h00;
      end
    end

    if (s.is_master) begin
      // Master sequencing and protection for the phase group
      core_next.sink  = 1'b0;
      case (core_reg.state)
        cfs_pkg::ST_OFF: begin
          core_next.run   = 1'b0;
          core_next.pg_oe = 1'b1;
          core_next.timer = '0;
          // Lockout flag carries the start/stop hysteresis of the comparator
          if (want_on && !s.input_lockout && !s.output_over_voltage &&
              !s.over_temperature) begin
            core_next.state    = cfs_pkg::ST_SOFT;
            core_next.run      = 1'b1;
            core_next.uv_armed = 1'b0;
          end
        end
        cfs_pkg::ST_SOFT: begin
          core_next.pg_oe = 1'b1;
          if (s.soft_start_done) begin
            core_next.state   = cfs_pkg::ST_PGWAIT;
            core_next.timer   = '0;
            core_next.arm_cnt = '0;
          end
        end
        cfs_pkg::ST_PGWAIT: begin
          core_next.pg_oe = 1'b1;
          if (s.fb_ready) begin
            core_next.timer = core_reg.timer + TW'(1);
            if (core_reg.timer >= TW'(PG_DELAY_CYC - 1)) begin
              core_next.state = cfs_pkg::ST_RUN;
              core_next.pg_oe = 1'b0;
              core_next.timer = '0;
            end
          end
        end
        cfs_pkg::ST_RUN: begin
          core_next.pg_oe = 1'b0;
          if (core_reg.timer < TW'(cfs_pkg::SLAVE_GRACE_CYC)) begin
            core_next.timer = core_reg.timer + TW'(1);
          end
        end
        cfs_pkg::ST_SINK: begin
          core_next.run   = 1'b0;
          core_next.sink  = 1'b1;
          core_next.pg_oe = 1'b1;
          if (s.output_under_voltage || !s.output_over_voltage) begin
            core_next.state = cfs_pkg::ST_HICCUP;
            core_next.sink  = 1'b0;
            core_next.timer = '0;
          end
        end
        cfs_pkg::ST_HICCUP: begin
          core_next.run   = 1'b0;
          core_next.pg_oe = 1'b1;
          core_next.timer = core_reg.timer + TW'(1);
          if (core_reg.timer >= TW'(HICCUP_CYC - 1)) begin
            core_next.state = cfs_pkg::ST_OFF;
            core_next.timer = '0;
          end
        end
        cfs_pkg::ST_OTWAIT: begin
          core_next.run   = 1'b0;
          core_next.pg_oe = 1'b1;
          if (!s.over_temperature) begin
            core_next.state = cfs_pkg::ST_OFF;
          end
        end
        default: begin
          core_next.state = cfs_pkg::ST_OFF;
          core_next.run   = 1'b0;
          core_next.pg_oe = 1'b1;
        end
      endcase

      // UV arming and debounce only while the output is up
      if (core_reg.state == cfs_pkg::ST_PGWAIT || core_reg.state == cfs_pkg::ST_RUN) begin
        if (core_reg.arm_cnt >= TW'(UV_ARM_CYC - 1)) begin
          core_next.uv_armed = 1'b1;
        end else begin
          core_next.arm_cnt = core_reg.arm_cnt + TW'(1);
        end
      end
      if (core_reg.uv_armed && s.output_under_voltage && active) begin
        core_next.uv_cnt = core_reg.uv_cnt + TW'(1);
      end else begin
        core_next.uv_cnt = '0;
      end

      // Protection while soft-starting or running, over-temperature in any state, highest priority last
      if (active) begin
        if (!want_on) begin
          core_next.state = cfs_pkg::ST_OFF;
          core_next.run   = 1'b0;
          core_next.pg_oe = 1'b1;
        end
        if (core_reg.state == cfs_pkg::ST_RUN && !s.pg_in &&
            core_reg.timer >= TW'(cfs_pkg::SLAVE_GRACE_CYC)) begin
          flag_set[cfs_pkg::FLG_SLAVE] = 1'b1;
          core_next.state = cfs_pkg::ST_HICCUP;
          core_next.timer = '0;
          core_next.run   = 1'b0;
          core_next.pg_oe = 1'b1;
        end
        if (core_reg.uv_armed && s.output_under_voltage &&
            core_reg.uv_cnt >= TW'(UV_DEBOUNCE_CYC - 1)) begin
          flag_set[cfs_pkg::FLG_UV] = 1'b1;
          core_next.state = cfs_pkg::ST_HICCUP;
          core_next.timer = '0;
          core_next.run   = 1'b0;
          core_next.pg_oe = 1'b1;
        end
        if (s.output_over_voltage) begin
          flag_set[cfs_pkg::FLG_OV] = 1'b1;
          core_next.state = cfs_pkg::ST_SINK;
          core_next.run   = 1'b0;
          core_next.sink  = 1'b1;
          core_next.pg_oe = 1'b1;
        end
        if (s.over_current) begin
          flag_set[cfs_pkg::FLG_OC] = 1'b1;
          core_next.state = cfs_pkg::ST_HICCUP;
          core_next.timer = '0;
          core_next.run   = 1'b0;
          core_next.sink  = 1'b0;
          core_next.pg_oe = 1'b1;
        end
      end
      if (s.over_temperature && core_reg.state != cfs_pkg::ST_OTWAIT) begin
        flag_set[cfs_pkg::FLG_OT] = 1'b1;
        core_next.state = cfs_pkg::ST_OTWAIT;
        core_next.run   = 1'b0;
        core_next.sink  = 1'b0;
        core_next.pg_oe = 1'b1;
      end
    end else begin
      // Slave: follows the master's run line and reports its own faults.
      // The synchroniser reads all-zero (slave, no fault) for two edges after
      // reset, so power-good stays pulled low for a short grace count first.
      core_next.state = cfs_pkg::ST_OFF;
      if (core_reg.timer < TW'(cfs_pkg::SLAVE_GRACE_CYC)) begin
        core_next.timer = core_reg.timer + TW'(1);
      end
      core_next.run   = s.run_in & ~s.input_lockout;
      core_next.sink  = s.output_over_voltage;
      core_next.pg_oe = (core_reg.timer < TW'(cfs_pkg::SLAVE_GRACE_CYC)) |
                        s.output_over_voltage | s.output_under_voltage |
                        s.over_temperature;
      flag_set[cfs_pkg::FLG_OV] = s.output_over_voltage;
      flag_set[cfs_pkg::FLG_UV] = s.output_under_voltage;
      flag_set[cfs_pkg::FLG_OT] = s.over_temperature;
    end

    // Missing input supply overrides state, run, sink and power-good
    if (s.input_lockout) begin
      if (s.is_master) begin
        flag_set[cfs_pkg::FLG_LOCKOUT] = core_reg.state != cfs_pkg::ST_OFF;
        core_next.state = cfs_pkg::ST_OFF;
      end
      core_next.run   = 1'b0;
      core_next.sink  = 1'b0;
      core_next.pg_oe = 1'b1;
    end

    // Clearing never loses an event arriving in the same cycle
    core_next.flags = (core_reg.flags & ~{cfs_pkg::FLAG_W{clear_faults}}) |
                      flag_set;
    core_next.alert_oe = |core_next.flags;
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_reg         <= '0;
      core_reg.state   <= cfs_pkg::ST_OFF;
      core_reg.pg_oe   <= 1'b1;
      core_reg.run_cmd <= cfs_pkg::RUN_CMD_RST;
      core_reg.ena_cfg <= cfs_pkg::ENA_CFG_RST;
    end else begin
      core_reg <= core_next;
    end
  end

  // Outputs straight from the state register; pins are open drain
  assign reg_rdata            = core_reg.rdata;
  assign reg_rvalid           = core_reg.rvalid;
  assign power_good_output_o  = 1'b0;
  assign power_good_output_oe = core_reg.pg_oe;
  assign alert_output_n_o     = 1'b0;
  assign alert_output_n_oe    = core_reg.alert_oe;
  assign converter_run        = core_reg.run;
  assign sink_mode            = core_reg.sink;
  assign fault_flags          = core_reg.flags;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_short;
    s.is_master && active && s.over_current && !s.input_lockout && !s.over_temperature;
  endsequence

  sequence s_hiccup_off;
    core_reg.state == cfs_pkg::ST_HICCUP && !converter_run && power_good_output_oe;
  endsequence

  AST_LOCKOUT_PG: assert property (s.input_lockout |=> power_good_output_oe)
    else $error("power-good not clamped low under input lockout");
  AST_ALWAYS_OFF: assert property (s.is_master &&
      core_reg.ena_cfg == cfs_pkg::CFG_ALWAYS_OFF |=> !converter_run)
    else $error("output ran with always-off enable source");
  AST_PIN_LOW_OFF: assert property (s.is_master &&
      core_reg.ena_cfg == cfs_pkg::CFG_PIN_ONLY && !s.enable_pin |=> !converter_run)
    else $error("output ran with enable pin low");
  AST_NO_START_OV: assert property (s.is_master &&
      core_reg.state == cfs_pkg::ST_OFF && s.output_over_voltage |=> !converter_run)
    else $error("start attempted during over-voltage");
  AST_SHORT_HICCUP: assert property (s_short |=> s_hiccup_off)
    else $error("short circuit did not enter hiccup");
  AST_HICCUP_HOLD: assert property (s.is_master && core_reg.state == cfs_pkg::ST_HICCUP &&
      core_reg.timer < TW'(HICCUP_CYC - 1) && !s.input_lockout && !s.over_temperature
      |=> core_reg.state == cfs_pkg::ST_HICCUP)
    else $error("hiccup ended early");
  AST_UV_UNARMED: assert property (!core_reg.uv_armed |-> core_reg.uv_cnt == '0)
    else $error("under-voltage counted before arming");
  AST_PG_LOW_IN_FAULT: assert property (s.is_master && core_reg.state != cfs_pkg::ST_RUN
      |-> power_good_output_oe)
    else $error("power-good released outside run");
  AST_SET_WINS: assert property (flag_set != '0 |=>
      (fault_flags & $past(flag_set)) == $past(flag_set))
    else $error("flag event lost against clear");
  AST_ALERT: assert property (alert_output_n_oe == (fault_flags != '0))
    else $error("alert does not match stored flags");
endmodule // cfs_supervisor
`default_nettype wire

// ---- logic/cfs_sync.sv ----
/*
  Two-flop level synchroniser for a vector of pin inputs.
  Assumes each bit is a slow level; no bus coherency is promised.
*/
`timescale 1ns/1ps
`default_nettype none
module cfs_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Levels
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } cfs_sync_st_t;

  cfs_sync_st_t sync_reg;
  cfs_sync_st_t sync_next;

  // First stage feeds only the second stage
  always_comb begin
    sync_next    = sync_reg;
    sync_next.s1 = d;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign q = sync_reg.s2;
endmodule // cfs_sync
`default_nettype wire

// ---- test/cfs_host_model.sv ----
/*
  Host-side partner: drives the remote enable pin and resolves the
  pulled-up power-good and alert wires.
  Assumes open-drain enables from the device, high while pulling low.
*/
`timescale 1ns/1ps
`default_nettype none
module cfs_host_model (
  // Host request
  input  wire logic want_on,
  // Device open-drain enables
  input  wire logic pg_oe,
  input  wire logic alert_oe,
  // Other phase pulling the shared power-good line
  input  wire logic peer_pull,
  // Resolved lines
  output var  logic enable_pin,
  output var  logic pg_wire,
  output var  logic alert_wire
);
  // Pull-ups win unless a party pulls low, so a released line reads high
  always_comb begin
    enable_pin = want_on;
    pg_wire    = !(pg_oe | peer_pull);
    alert_wire = !alert_oe;
  end
endmodule // cfs_host_model
`default_nettype wire

// ---- test/converter_fault_supervisor_test.sv ----
/*
  Self-checking bench for the supervisor with shortened delay counts.
  Assumes the host model resolves the open-drain lines.
*/
`timescale 1ns/1ps
`default_nettype none
module converter_fault_supervisor_test;
  logic       clk, rst, wr, rd, clr, lko, uv, ov, ot, oc, ssd, fb, mst, want, run_in;
  logic [7:0] addr, wd, rdat;
  logic       rv, pg_o, pg_oe, al_o, al_oe, run, sink, en, pg_w, al_w, peer;
  logic [5:0] flg;
  int         n_fail, cmp_count, cyc;

  // Short counts keep each hiccup and debounce to tens of cycles
  cfs_supervisor #(.UV_DEBOUNCE_CYC(20), .HICCUP_CYC(50), .UV_ARM_CYC(30),
    .PG_DELAY_CYC(10)) DUT (.clk(clk), .rst(rst), .reg_wr(wr), .reg_rd(rd),
    .reg_addr(addr), .reg_wdata(wd), .clear_faults(clr), .reg_rdata(rdat),
    .reg_rvalid(rv), .input_lockout(lko), .output_under_voltage(uv),
    .output_over_voltage(ov), .over_temperature(ot), .over_current(oc),
    .soft_start_done(ssd), .fb_ready(fb), .is_master(mst), .enable_pin(en),
    .run_in(run_in), .power_good_output_i(pg_w), .power_good_output_o(pg_o),
    .power_good_output_oe(pg_oe), .alert_output_n_o(al_o),
    .alert_output_n_oe(al_oe), .converter_run(run), .sink_mode(sink),
    .fault_flags(flg));
  cfs_host_model host (.want_on(want), .pg_oe(pg_oe), .alert_oe(al_oe),
    .peer_pull(peer), .enable_pin(en), .pg_wire(pg_w), .alert_wire(al_w));

  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic cy(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bit1(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask
  // Strobes raised at a falling edge, taken at the next rising edge
  task automatic rwr(input logic [7:0] a, input logic [7:0] d);
    wr = 1'b1;
    addr = a;
    wd = d;
    cy(1);
    wr = 1'b0;
    cy(1); // Idle edge so a following call never re-raises the strobe at once
  endtask
  task automatic rrd(input logic [7:0] a, input logic [7:0] e);
    rd = 1'b1;
    addr = a;
    cy(1);
    rd = 1'b0;
    bit1(rv, 1'b1);
    chk(rdat, e);
    cy(1); // Idle edge so a following call never re-raises the strobe at once
  endtask

  task automatic t_regs;
    rrd(8'h02, 8'h16);
    bit1(pg_oe, 1'b1);
    rrd(8'h01, 8'h00);
    rwr(8'h05, 8'hff);
    rrd(8'h05, 8'h00);
    rwr(8'h01, 8'h80);
    rrd(8'h01, 8'h80);
  endtask
  // Every enable source against every bit and pin combination
  task automatic t_cfg;
    logic [7:0] c [5] = '{8'h16, 8'h1a, 8'h1e, 8'h12, 8'h03};
    logic       e;
    for (int i = 0; i < 20; i++) begin
      rwr(8'h02, c[i/4]);
      rwr(8'h01, {i[0], 7'h00});
      want = i[1];
      cy(6);
      case (c[i/4])
        8'h16: e = i[1];
        8'h1a: e = i[0];
        8'h1e: e = i[0] & i[1];
        8'h12: e = 1'b0;
        default: e = 1'b1;
      endcase
      bit1(run, e);
    end
    rwr(8'h02, 8'h16);
  endtask
  // Start-up, early UV ignored, armed UV trips and hiccups, flags clear
  task automatic t_start_uv;
    cy(5);
    bit1(pg_oe, 1'b1);
    ssd = 1'b1;
    fb = 1'b1;
    cy(10);
    bit1(pg_oe, 1'b1);
    cy(8);
    bit1(pg_w, 1'b1);
    uv = 1'b1;
    cy(25);
    uv = 1'b0;
    bit1(run, 1'b1);
    cy(5);
    uv = 1'b1;
    cy(26);
    bit1(run, 1'b0);
    bit1(pg_oe, 1'b1);
    bit1(flg[1], 1'b1);
    bit1(al_w, 1'b0);
    bit1(al_o, 1'b0);
    bit1(pg_o, 1'b0);
    uv = 1'b0;
    cy(40);
    bit1(run, 1'b0);
    cy(20);
    bit1(run, 1'b1);
    clr = 1'b1;
    cy(1);
    clr = 1'b0;
    chk({2'b00, flg}, 8'h00);
    bit1(al_oe, 1'b0);
  endtask
  // Temperature, over-voltage sink, short circuit and input lockout
  task automatic t_faults;
    ot = 1'b1;
    cy(4);
    bit1(run, 1'b0);
    bit1(flg[3], 1'b1);
    ot = 1'b0;
    cy(6);
    bit1(run, 1'b1);
    ov = 1'b1;
    cy(4);
    bit1(sink, 1'b1);
    uv = 1'b1;
    cy(4);
    uv = 1'b0;
    cy(60);
    bit1(run, 1'b0);
    bit1(sink, 1'b0);
    ov = 1'b0;
    cy(6);
    bit1(run, 1'b1);
    oc = 1'b1;
    cy(4);
    bit1(run, 1'b0);
    cy(30);
    oc = 1'b0;
    cy(70);
    bit1(run, 1'b1);
    lko = 1'b1;
    cy(4);
    bit1(run, 1'b0);
    bit1(pg_w, 1'b0);
    lko = 1'b0;
    cy(6);
    bit1(run, 1'b1);
  endtask
  // Other phase pulls power-good low while running: master hiccups and flags it
  task automatic t_peer;
    cy(20);
    bit1(pg_w, 1'b1);
    peer = 1'b1;
    cy(4);
    peer = 1'b0;
    bit1(run, 1'b0);
    bit1(flg[5], 1'b1);
    bit1(pg_oe, 1'b1);
  endtask
  // Slave phase follows the run line and reports faults on power-good
  task automatic t_slave;
    mst = 1'b0;
    run_in = 1'b1;
    ov = 1'b1;
    cy(5);
    bit1(run, 1'b1);
    bit1(pg_w, 1'b0);
    ov = 1'b0;
    cy(5);
    bit1(pg_oe, 1'b0);
  endtask

  task automatic give_verdict;
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst, wr, rd, clr, lko, uv, ov, ot, oc, ssd, fb, want, run_in, peer} = 14'h2000;
    {addr, wd, mst} = {16'h0000, 1'b1};
    cy(5);
    rst = 1'b0;
    t_regs();
    t_cfg();
    t_start_uv();
    t_faults();
    t_peer();
    t_slave();
    give_verdict();
  end
endmodule // converter_fault_supervisor_test
`default_nettype wire
